// *** design/ddr_burst_pkg.sv ***
package ddr_burst_pkg;

   // Array and lane geometry
   localparam int LANE_W     = 9;
   localparam int DATA_W     = 36;
   localparam int LANES      = DATA_W / LANE_W;
   localparam int ADDR_W     = 8;
   localparam int DEPTH      = 1 << ADDR_W;
   localparam int FIFO_DEPTH = 8;

   // Burst partner address differs in bit 0 only
   localparam logic [ADDR_W-1:0] BURST_FLIP = ADDR_W'(1);

   // Idle levels of the link
   localparam logic [LANES-1:0]  MASK_IDLE = {LANES{1'b1}};
   localparam logic [DATA_W-1:0] DATA_RST  = '0;

   // Controller read capture taps, in system clocks after the issuing edge
   localparam int RD_PIPE   = 7;
   localparam int RD_W0_DLL = 4;
   localparam int RD_W1_DLL = 5;
   localparam int RD_W0_LEG = 3;
   localparam int RD_W1_LEG = 4;

   // Device output sequencer
   typedef enum logic [3:0] {
      OUT_IDLE   = 4'h1,
      OUT_FIRST  = 4'h2,
      OUT_SECOND = 4'h4,
      OUT_LAST   = 4'h8
   } out_state_e;

   // One queued burst request
   typedef struct packed {
      logic              is_read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data0;
      logic [DATA_W-1:0] data1;
      logic [LANES-1:0]  mask0_n;
      logic [LANES-1:0]  mask1_n;
   } burst_cmd_s;

   localparam int CMD_W = $bits(burst_cmd_s);

endpackage

// *** design/burst_link.sv ***
`timescale 1ns/1ps
interface burst_link;
   import ddr_burst_pkg::*;

   logic              k_clk;
   logic              k_clk_n;
   logic              c_clk;
   logic              c_clk_n;
   logic              transfer_strobe_n;
   logic              read_select;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0]  lane_write_mask_n;
   logic              lock_loop_disable_n;
   logic [DATA_W-1:0] ctrl_dq;
   logic              ctrl_dq_oe_n;
   logic [DATA_W-1:0] dev_q;
   logic              dev_q_oe_n;
   logic [DATA_W-1:0] dq;

   // Shared data wire, device drive wins when both drive
   assign dq = !dev_q_oe_n ? dev_q : (!ctrl_dq_oe_n ? ctrl_dq : DATA_RST);

   modport controller (
      output k_clk, k_clk_n, c_clk, c_clk_n, transfer_strobe_n, read_select, addr,
             lane_write_mask_n, lock_loop_disable_n, ctrl_dq, ctrl_dq_oe_n,
      input  dq
   );

   modport memory (
      input  k_clk, k_clk_n, c_clk, c_clk_n, transfer_strobe_n, read_select, addr,
             lane_write_mask_n, lock_loop_disable_n, dq,
      output dev_q, dev_q_oe_n
   );
endinterface

// *** design/ddr_burst_device.sv ***
`timescale 1ns/1ps
module ddr_burst_device (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   burst_link.memory   link,
   output logic        single_clock_mode_o
);
   import ddr_burst_pkg::*;

   logic [DATA_W-1:0] mem [DEPTH];

   logic              k_prev;
   logic              kn_prev;
   logic              c_prev;
   logic              cn_prev;
   logic              strap_taken;
   logic              k_rise;
   logic              kn_rise;
   logic              pos_edge;
   logic              neg_edge;
   logic              legacy;

   logic              wr_armed;
   logic              wr_second;
   logic              rd_armed;
   logic [ADDR_W-1:0] cmd_addr;
   logic [ADDR_W-1:0] second_addr;

   logic              beat_en;
   logic [ADDR_W-1:0] beat_addr;
   logic [DATA_W-1:0] beat_old;
   logic [DATA_W-1:0] beat_new;

   logic [DATA_W-1:0] rd_word0;
   logic [DATA_W-1:0] rd_word1;
   out_state_e        out_state;
   logic              start_read;

   // Edge detection on link clocks; no edge, no action
   assign k_rise   = link.k_clk & ~k_prev;
   assign kn_rise  = link.k_clk_n & ~kn_prev;
   assign pos_edge = single_clock_mode_o ? k_rise : (link.c_clk & ~c_prev);
   assign neg_edge = single_clock_mode_o ? kn_rise : (link.c_clk_n & ~cn_prev);
   assign legacy   = ~link.lock_loop_disable_n;

   // Previous clock levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         k_prev  <= 1'b0;
         kn_prev <= 1'b0;
         c_prev  <= 1'b1;
         cn_prev <= 1'b1;
      end else begin
         k_prev  <= link.k_clk;
         kn_prev <= link.k_clk_n;
         c_prev  <= link.c_clk;
         cn_prev <= link.c_clk_n;
      end
   end

   // Single clock strap caught once, just after reset release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_taken         <= 1'b0;
         single_clock_mode_o <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken         <= 1'b1;
         single_clock_mode_o <= link.c_clk & link.c_clk_n;
      end
   end

   // Command capture on each K rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_armed    <= 1'b0;
         wr_second   <= 1'b0;
         rd_armed    <= 1'b0;
         cmd_addr    <= '0;
         second_addr <= '0;
      end else if (k_rise) begin
         // Strobe high: no operation, direction ignored
         wr_armed  <= ~link.transfer_strobe_n & ~link.read_select;
         rd_armed  <= ~link.transfer_strobe_n & link.read_select;
         wr_second <= wr_armed;
         if (!link.transfer_strobe_n) begin
            cmd_addr <= link.addr;
         end
         if (wr_armed) begin
            second_addr <= cmd_addr ^ BURST_FLIP;
         end
      end else if (kn_rise) begin
         wr_second <= 1'b0;
      end
   end

   // Write beat: first at K of t+1, second at K# of t+1
   always_comb begin
      beat_en   = 1'b0;
      beat_addr = cmd_addr;
      if (k_rise && wr_armed) begin
         beat_en   = 1'b1;
         beat_addr = cmd_addr;
      end else if (kn_rise && wr_second) begin
         beat_en   = 1'b1;
         beat_addr = second_addr;
      end
   end

   assign beat_old = mem[beat_addr];

   // Lane merge; mask taken with this beat only
   generate
      for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
         assign beat_new[lane*LANE_W +: LANE_W] =
            link.lane_write_mask_n[lane] ? beat_old[lane*LANE_W +: LANE_W]
                                         : link.dq[lane*LANE_W +: LANE_W];
      end
   endgenerate

   // Array update; all masks high leaves the word alone
   always_ff @(posedge clk_i) begin
      if (beat_en && (link.lane_write_mask_n != MASK_IDLE)) begin
         mem[beat_addr] <= beat_new;
      end
   end

   // Read fetch happens at K of t+1; array already holds earlier writes
   assign start_read = k_rise & rd_armed;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_word0 <= DATA_RST;
         rd_word1 <= DATA_RST;
      end else if (start_read) begin
         rd_word0 <= mem[cmd_addr];
         rd_word1 <= mem[cmd_addr ^ BURST_FLIP];
      end
   end

   // Output sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_state       <= OUT_IDLE;
         link.dev_q      <= DATA_RST;
         link.dev_q_oe_n <= 1'b1;
      end else begin
         case (out_state)
            OUT_IDLE: begin
               if (start_read && legacy) begin
                  // One cycle latency: first word on this K rise
                  link.dev_q      <= mem[cmd_addr];
                  link.dev_q_oe_n <= 1'b0;
                  out_state       <= OUT_SECOND;
               end else if (start_read) begin
                  out_state <= OUT_FIRST;
               end
            end
            OUT_FIRST: begin
               if (neg_edge) begin
                  link.dev_q      <= rd_word0;
                  link.dev_q_oe_n <= 1'b0;
                  out_state       <= OUT_SECOND;
               end
            end
            OUT_SECOND: begin
               if (legacy && kn_rise) begin
                  link.dev_q <= rd_word1;
                  out_state  <= OUT_LAST;
               end else if (!legacy && pos_edge) begin
                  link.dev_q <= rd_word1;
                  out_state  <= start_read ? OUT_FIRST : OUT_LAST;
               end
            end
            OUT_LAST: begin
               if (legacy && start_read) begin
                  link.dev_q <= mem[cmd_addr];
                  out_state  <= OUT_SECOND;
               end else if (start_read) begin
                  out_state <= OUT_FIRST;
               end else if (legacy ? k_rise : neg_edge) begin
                  // Release half a link cycle after the last word; frees the wire for a write
                  link.dev_q_oe_n <= 1'b1;
                  out_state       <= OUT_IDLE;
               end
            end
            default: begin
               out_state       <= OUT_IDLE;
               link.dev_q_oe_n <= 1'b1;
            end
         endcase
      end
   end

endmodule

// *** design/ddr_burst_controller.sv ***
`timescale 1ns/1ps
module burst_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic [PW:0]      next_count;
   logic             push;
   logic             pop;

   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = store[rd_ptr];
   assign next_count  = count + (PW+1)'(push) - (PW+1)'(pop);

   // Pointers, occupancy and honest flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr      <= '0;
         rd_ptr      <= '0;
         count       <= '0;
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count       <= next_count;
         in_ready_o  <= next_count != (PW+1)'(DEPTH);
         out_valid_o <= next_count != '0;
      end
   end

   // Storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         store[wr_ptr] <= in_data_i;
      end
   end
endmodule

module ddr_burst_controller (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   burst_link.controller                      link,
   input  wire logic                          cmd_valid_i,
   input  wire ddr_burst_pkg::burst_cmd_s     cmd_i,
   output logic                               cmd_ready_o,
   input  wire logic                          clock_run_i,
   input  wire logic                          single_clock_i,
   input  wire logic                          dll_off_i,
   output logic                               rd_valid_o,
   output logic [ddr_burst_pkg::DATA_W-1:0]   rd_data0_o,
   output logic [ddr_burst_pkg::DATA_W-1:0]   rd_data1_o
);
   import ddr_burst_pkg::*;

   burst_cmd_s        head;
   logic              head_valid;
   logic              ph;
   logic              at_rise;
   logic              at_fall;
   logic              busy;
   logic              issue;
   logic              prev_read;
   logic              wr_b0;
   logic              wr_b1;
   logic [DATA_W-1:0] d0;
   logic [DATA_W-1:0] d1;
   logic [LANES-1:0]  m0;
   logic [LANES-1:0]  m1;
   logic [DATA_W-1:0] b1_data;
   logic [LANES-1:0]  b1_mask;
   logic [RD_PIPE-1:0] rd_sh;
   logic [DATA_W-1:0] word0;

   burst_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) burst_fifo_i (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (cmd_valid_i),
      .in_data_i   (cmd_i),
      .in_ready_o  (cmd_ready_o),
      .out_valid_o (head_valid),
      .out_data_o  (head),
      .out_ready_i (issue)
   );

   assign busy    = head_valid | wr_b0 | wr_b1 | (|rd_sh);
   assign at_rise = ph & (clock_run_i | busy);
   assign at_fall = ~ph;
   // Read followed by write needs one empty slot
   assign issue   = at_rise & head_valid & ~(~head.is_read & prev_read);

   // Link clock divider; stops with both K low, C pair high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph           <= 1'b1;
         link.k_clk   <= 1'b0;
         link.k_clk_n <= 1'b0;
         link.c_clk   <= single_clock_i;
         link.c_clk_n <= 1'b1;
      end else if (at_rise) begin
         ph           <= 1'b0;
         link.k_clk   <= 1'b1;
         link.k_clk_n <= 1'b0;
         link.c_clk   <= 1'b1;
         link.c_clk_n <= single_clock_i;
      end else if (at_fall) begin
         ph           <= 1'b1;
         link.k_clk   <= 1'b0;
         link.k_clk_n <= 1'b1;
         link.c_clk   <= single_clock_i;
         link.c_clk_n <= 1'b1;
      end else begin
         link.k_clk   <= 1'b0;
         link.k_clk_n <= 1'b0;
         link.c_clk   <= 1'b1;
         link.c_clk_n <= 1'b1;
      end
   end

   // Command slot on each K rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link.transfer_strobe_n   <= 1'b1;
         link.read_select         <= 1'b0;
         link.addr                <= '0;
         link.lock_loop_disable_n <= 1'b1;
         prev_read                <= 1'b0;
      end else begin
         link.lock_loop_disable_n <= ~dll_off_i;
         if (at_rise) begin
            link.transfer_strobe_n <= ~issue;
            link.read_select       <= issue & head.is_read;
            link.addr              <= issue ? head.addr : link.addr;
            prev_read              <= issue & head.is_read;
         end
      end
   end

   // Write beats at K of t+1 and K# of t+1, each with its own mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_b0                  <= 1'b0;
         wr_b1                  <= 1'b0;
         d0                     <= DATA_RST;
         d1                     <= DATA_RST;
         m0                     <= MASK_IDLE;
         m1                     <= MASK_IDLE;
         b1_data                <= DATA_RST;
         b1_mask                <= MASK_IDLE;
         link.ctrl_dq           <= DATA_RST;
         link.ctrl_dq_oe_n      <= 1'b1;
         link.lane_write_mask_n <= MASK_IDLE;
      end else if (at_rise) begin
         wr_b0                  <= issue & ~head.is_read;
         d0                     <= head.data0;
         d1                     <= head.data1;
         m0                     <= head.mask0_n;
         m1                     <= head.mask1_n;
         wr_b1                  <= wr_b0;
         b1_data                <= d1;
         b1_mask                <= m1;
         link.ctrl_dq           <= d0;
         link.ctrl_dq_oe_n      <= ~wr_b0;
         link.lane_write_mask_n <= wr_b0 ? m0 : MASK_IDLE;
      end else if (at_fall) begin
         wr_b1                  <= 1'b0;
         link.ctrl_dq           <= b1_data;
         link.ctrl_dq_oe_n      <= ~wr_b1;
         link.lane_write_mask_n <= wr_b1 ? b1_mask : MASK_IDLE;
      end else begin
         // Link clock stopped: let go of the wire
         link.ctrl_dq_oe_n      <= 1'b1;
         link.lane_write_mask_n <= MASK_IDLE;
      end
   end

   // Read return capture at fixed taps after the issuing edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_sh      <= '0;
         word0      <= DATA_RST;
         rd_valid_o <= 1'b0;
         rd_data0_o <= DATA_RST;
         rd_data1_o <= DATA_RST;
      end else begin
         rd_sh      <= {rd_sh[RD_PIPE-2:0], issue & head.is_read};
         rd_valid_o <= 1'b0;
         if (dll_off_i ? rd_sh[RD_W0_LEG] : rd_sh[RD_W0_DLL]) begin
            word0 <= link.dq;
         end
         if (dll_off_i ? rd_sh[RD_W1_LEG] : rd_sh[RD_W1_DLL]) begin
            rd_data0_o <= word0;
            rd_data1_o <= link.dq;
            rd_valid_o <= 1'b1;
         end
      end
   end

endmodule

// *** test/ddr_burst2_sram_port_chk.sv ***
`timescale 1ns/1ps
module ddr_burst2_sram_port_chk (
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   input  wire logic                              k_clk,
   input  wire logic                              k_clk_n,
   input  wire logic                              transfer_strobe_n,
   input  wire logic                              read_select,
   input  wire logic [ddr_burst_pkg::LANES-1:0]   lane_write_mask_n,
   input  wire logic                              lock_loop_disable_n,
   input  wire logic                              ctrl_dq_oe_n,
   input  wire logic                              dev_q_oe_n
);
   import ddr_burst_pkg::*;

   logic k_q;
   logic kn_q;
   logic k_rise;
   logic kn_rise;
   logic rd_start;
   logic wr_start;

   // Previous link clock levels
   always_ff @(posedge clk_i) begin
      k_q  <= k_clk;
      kn_q <= k_clk_n;
   end

   // Link clock rises and operation starts as the device sees them
   assign k_rise   = k_clk & ~k_q;
   assign kn_rise  = k_clk_n & ~kn_q;
   assign rd_start = k_rise & ~transfer_strobe_n & read_select;
   assign wr_start = k_rise & ~transfer_strobe_n & ~read_select;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_IDLE_AFTER_RESET: assert property ($fell(rst_i) |-> dev_q_oe_n && ctrl_dq_oe_n)
      else $error("data wire driven right after reset");
   AST_READ_LATENCY: assert property (rd_start && lock_loop_disable_n |-> ##4 !dev_q_oe_n [*2])
      else $error("read words not driven at the expected cycles");
   AST_READ_LATENCY_LEGACY: assert property (rd_start && !lock_loop_disable_n |-> ##3 !dev_q_oe_n [*2])
      else $error("legacy read words not driven at the expected cycles");
   AST_DRIVE_NEEDS_READ: assert property ($fell(dev_q_oe_n) && lock_loop_disable_n |-> $past(rd_start, 4))
      else $error("device drove the wire without a read");
   AST_WRITE_BEATS: assert property (wr_start |-> ##2 (k_rise && !ctrl_dq_oe_n) ##1 (kn_rise && !ctrl_dq_oe_n))
      else $error("write beats not on the next link clock rises");
   AST_READ_TO_WRITE_GAP: assert property (wr_start |-> !$past(rd_start, 2))
      else $error("write started right after a read");
   AST_MASK_IDLE: assert property (ctrl_dq_oe_n |-> lane_write_mask_n == MASK_IDLE)
      else $error("lane masks active outside write beats");
   AST_STOPPED_HOLD: assert property ((!k_clk && !k_clk_n) [*2] |-> $stable(dev_q_oe_n))
      else $error("device output changed with link clock stopped");
   AST_NO_CONTENTION: assert property (!(!dev_q_oe_n && !ctrl_dq_oe_n))
      else $error("both ends drive the data wire");

   // Main scenarios
   cover property (rd_start && lock_loop_disable_n);
   cover property (rd_start && !lock_loop_disable_n);
   cover property (wr_start);
   cover property (!ctrl_dq_oe_n && lane_write_mask_n != MASK_IDLE && lane_write_mask_n != '0);
endmodule

// *** test/test_ddr_burst2_sram_port.sv ***
`timescale 1ns/1ps
module test_ddr_burst2_sram_port;
   import ddr_burst_pkg::*;

   logic                  clk_i        = 1'b0;
   logic                  rst_i        = 1'b1;
   logic                  cmd_valid    = 1'b0;
   logic                  clock_run    = 1'b0;
   logic                  single_clock = 1'b0;
   logic                  dll_off      = 1'b0;
   burst_cmd_s            cmd          = '0;
   logic                  cmd_ready;
   logic                  rd_valid;
   logic                  scm;
   logic [DATA_W-1:0]     rd0;
   logic [DATA_W-1:0]     rd1;
   logic [DATA_W-1:0]     mem [DEPTH];
   logic [2*DATA_W-1:0]   expq [$];
   int                    num_errors   = 0;
   int                    cmp_count    = 0;
   int                    cycles       = 0;

   always #5 clk_i = ~clk_i;

   burst_link burst_link_i ();

   ddr_burst_device ddr_burst_device_i (
      .clk_i               (clk_i),
      .rst_i               (rst_i),
      .link                (burst_link_i.memory),
      .single_clock_mode_o (scm)
   );

   ddr_burst_controller ddr_burst_controller_i (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .link           (burst_link_i.controller),
      .cmd_valid_i    (cmd_valid),
      .cmd_i          (cmd),
      .cmd_ready_o    (cmd_ready),
      .clock_run_i    (clock_run),
      .single_clock_i (single_clock),
      .dll_off_i      (dll_off),
      .rd_valid_o     (rd_valid),
      .rd_data0_o     (rd0),
      .rd_data1_o     (rd1)
   );

   ddr_burst2_sram_port_chk ddr_burst2_sram_port_chk_i (
      .clk_i               (clk_i),
      .rst_i               (rst_i),
      .k_clk               (burst_link_i.k_clk),
      .k_clk_n             (burst_link_i.k_clk_n),
      .transfer_strobe_n   (burst_link_i.transfer_strobe_n),
      .read_select         (burst_link_i.read_select),
      .lane_write_mask_n   (burst_link_i.lane_write_mask_n),
      .lock_loop_disable_n (burst_link_i.lock_loop_disable_n),
      .ctrl_dq_oe_n        (burst_link_i.ctrl_dq_oe_n),
      .dev_q_oe_n          (burst_link_i.dev_q_oe_n)
   );

   task automatic check_data(input logic [2*DATA_W-1:0] exp, input logic [2*DATA_W-1:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected read burst: expected %h, seen %h", exp, got);
      end
   endtask

   task automatic check_flag(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // Issue one burst; note its effect once the queue takes it
   task automatic send(input logic rd, input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] m0, input logic [LANES-1:0] m1);
      logic [DATA_W-1:0] d0;
      logic [DATA_W-1:0] d1;
      d0 = DATA_W'({$urandom(), $urandom()});
      d1 = DATA_W'({$urandom(), $urandom()});
      cmd <= '{rd, a, d0, d1, m0, m1};
      cmd_valid <= 1'b1;
      @(posedge clk_i);
      while (cmd_ready !== 1'b1) @(posedge clk_i);
      if (rd) begin
         expq.push_back({mem[a], mem[a ^ BURST_FLIP]});
      end else begin
         for (int l = 0; l < LANES; l++) begin
            if (!m0[l]) mem[a][l*LANE_W +: LANE_W] = d0[l*LANE_W +: LANE_W];
            if (!m1[l]) mem[a ^ BURST_FLIP][l*LANE_W +: LANE_W] = d1[l*LANE_W +: LANE_W];
         end
      end
   endtask

   task automatic idle(input int n);
      cmd_valid <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask

   // One reset and traffic run in a given clocking mode
   task automatic run_phase(input logic sc, input logic dll);
      single_clock <= sc;
      dll_off <= dll;
      clock_run <= 1'($urandom());
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check_flag("device drive", 1'b1, burst_link_i.dev_q_oe_n);
      check_flag("single clock strap", sc, scm);
      @(posedge clk_i);
      for (int a = 0; a < 16; a++) send(1'b0, ADDR_W'(a), '0, '0);
      for (int l = 0; l < LANES; l++) send(1'b0, ADDR_W'(4 + l), ~LANES'(1 << l), ~LANES'(8 >> l));
      send(1'b0, ADDR_W'(3), MASK_IDLE, LANES'(4'h5));
      repeat (24) send(1'($urandom()), ADDR_W'($urandom() % 16), LANES'($urandom()), LANES'($urandom()));
      clock_run <= 1'b0;
      idle(40);
      for (int a = 0; a < 16; a++) send(1'b1, ADDR_W'(a), MASK_IDLE, MASK_IDLE);
      idle(1);
      for (int i = 0; i < 500 && expq.size() != 0; i++) @(posedge clk_i);
      check_flag("all reads answered", 1'b1, expq.size() == 0);
   endtask

   task automatic complete_run();
      $display("errors %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Compare each returned burst with the oldest note
   always @(posedge clk_i) begin
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0) check_flag("read pulse", 1'b0, 1'b1);
         else check_data(expq.pop_front(), {rd0, rd1});
      end
   end

   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("unexpected run length: expected below %0d, seen %0d", 20000, cycles);
         complete_run();
      end
   end

   initial begin
      void'($urandom(68));
      run_phase(1'b0, 1'b0);
      run_phase(1'b1, 1'b0);
      run_phase(1'b1, 1'b1);
      run_phase(1'b0, 1'b1);
      complete_run();
   end
endmodule
